// ===== sfm_pkg.sv
/*
 * sfm_pkg: shared constants of the safety fault monitor.
 * It holds the register offsets, field positions, fault values, message identifiers and timing figures.
 * Assumes: a single 125 MHz system clock and a 32-bit APB register bus.
 */
`default_nettype none
package sfm_pkg;
	// bus geometry
	localparam int DW = 32; // apb data width
	localparam int AW = 8; // apb address width
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00; // ack pulse, terminal enables
	localparam logic [7:0] OFS_TOL = 8'h04; // changeover tolerance, clock cycles
	localparam logic [7:0] OFS_STAT = 8'h08; // live fault state
	localparam logic [7:0] OFS_STOP_VAL = 8'h0C; // fault value of immediate stop
	localparam logic [7:0] OFS_DEF_VAL = 8'h10; // fault value of channel defect
	localparam logic [7:0] OFS_STOP_ID = 8'h14; // message id, immediate stop
	localparam logic [7:0] OFS_DEF_ID = 8'h18; // message id, channel defect
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1C; // sticky events, clear on read
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20; // interrupt enables
	localparam logic [7:0] OFS_XCHK = 8'h24; // cross-check mismatch report
	// field positions
	localparam int CTRL_ACK = 0; // write 1: acknowledge
	localparam int CTRL_EN1 = 1; // terminal_torque_off_enable_ch1
	localparam int CTRL_EN2 = 2; // terminal_torque_off_enable_ch2
	localparam int ST_STOP = 0; // immediate_stop_fault latched
	localparam int ST_DEF = 1; // channel_defect_fault latched
	localparam int ST_BUSY = 2; // chatter check running
	localparam int ST_INH = 3; // pulse inhibit driven
	localparam int IRQ_W = 2; // event bits: stop, defect
	// fault values
	typedef logic [15:0] sfm_fval_t;
	localparam sfm_fval_t FV_P2_STOP = 16'h0000; // 0
	localparam sfm_fval_t FV_XCHK_MIN = 16'h0001; // 1
	localparam sfm_fval_t FV_XCHK_MAX = 16'h03E7; // 999
	localparam sfm_fval_t FV_CHATTER = 16'h03E8; // 1000
	localparam sfm_fval_t FV_INIT_CHG = 16'h03E9; // 1001
	localparam sfm_fval_t FV_INIT_CHK = 16'h03EA; // 1002
	localparam sfm_fval_t FV_PULSE = 16'h03ED; // 1005
	localparam sfm_fval_t FV_TERM_DISC = 16'h0406; // 1030
	localparam sfm_fval_t FV_SEL_DISC = 16'h07D0; // 2000
	localparam sfm_fval_t FV_CHK_DISC = 16'h07D1; // 2001
	localparam sfm_fval_t FV_SEEN_DISC = 16'h07D3; // 2003
	localparam sfm_fval_t FV_CONSEQ = 16'h270F; // 9999
	// message identifiers: class letter over number
	localparam logic [7:0] CLASS_FAULT = 8'h46; // 'F'
	localparam logic [7:0] CLASS_ALARM = 8'h41; // 'A'
	localparam logic [7:0] CLASS_SAFETY = 8'h43; // 'C', either class
	localparam logic [23:0] NUM_STOP = 24'h000640; // 1600
	localparam logic [23:0] NUM_DEF = 24'h00064B; // 1611
	// timing
	localparam int CLK_NS = 8; // pclk period
	localparam int TOL_DEFAULT_NS = 1000000; // default tolerance, 1 ms
	localparam int TOL_DEFAULT_CYC = TOL_DEFAULT_NS / CLK_NS; // rounds down
	localparam logic [2:0] CHAT_MULT = 3'h5; // check window in tolerance times
	localparam int TOL_W = 24; // tolerance counter width
	// chatter checker states
	typedef enum logic [0:0] {CH_IDLE = 1'b0, CH_WATCH = 1'b1} sfm_chat_st_t;

	// builds a message identifier from class and number
	function automatic logic [31:0] sfm_msg_id(input logic [7:0] cls, input logic [23:0] num);
		return {cls, num};
	endfunction : sfm_msg_id

	// true for every offset that the register file decodes
	function automatic logic sfm_mapped(input logic [7:0] a);
		return (a <= OFS_XCHK) && (a[1:0] == 2'h0);
	endfunction : sfm_mapped
endpackage : sfm_pkg
`default_nettype wire

// ===== sfm_chat_if.sv
/*
 * sfm_chat_if: link between the fault monitor top and its chatter checker.
 * Assumes: both ends run on pclk; all signals are same-domain.
 */
`default_nettype none
interface sfm_chat_if #(parameter int TW = sfm_pkg::TOL_W);
	logic [1:0] sel; // synchronised torque-off selections
	logic [TW-1:0] tol; // tolerance in cycles
	logic ack; // one-cycle acknowledge
	logic busy; // check window open
	logic fault; // chatter or init fault held until ack
	sfm_pkg::sfm_fval_t code; // value belonging to fault
	modport chk (input sel, tol, ack, output busy, fault, code);
	modport top (output sel, tol, ack, input busy, fault, code);
endinterface : sfm_chat_if
`default_nettype wire

// ===== sfm_sync.sv
/*
 * sfm_sync: two-flop synchroniser for a vector of pin levels.
 * Assumes: each bit is an independent level; no word coherence is promised.
 */
`default_nettype none
module sfm_sync #(parameter int W = 1) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1; // first stage, read only by s2
		logic [W-1:0] s2; // settled copy
	} sfm_sync_st_t;
	sfm_sync_st_t s_r, s_nxt;

	// shift the pins one stage per clock
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.s2;
endmodule : sfm_sync
`default_nettype wire

// ===== sfm_chatter.sv
/*
 * sfm_chatter: watches the selection signals for chattering against the tolerance time.
 * Assumes: sel is already synchronised; tol is stable while a window is open.
 */
`default_nettype none
module sfm_chatter #(parameter int TW = sfm_pkg::TOL_W) (
	input wire logic pclk,
	input wire logic presetn,
	sfm_chat_if.chk ci
);
	typedef struct packed {
		sfm_pkg::sfm_chat_st_t st; // idle or watching
		logic [1:0] sel_q; // previous selection
		logic [TW+2:0] elapsed; // cycles since window opened
		logic [TW-1:0] since; // cycles since last change
		logic fault; // held until ack
		sfm_pkg::sfm_fval_t code; // value of held fault
	} sfm_chatter_st_t;
	sfm_chatter_st_t s_r, s_nxt;
	logic chg; // selection changed this cycle
	logic [TW+2:0] lim; // five tolerance times

	// window logic: open on change, close on stability or expiry
	always_comb begin
		s_nxt = s_r;
		chg = (ci.sel != s_r.sel_q);
		lim = {3'h0, ci.tol} * {{TW{1'b0}}, sfm_pkg::CHAT_MULT};
		s_nxt.sel_q = ci.sel;
		// ack clears only with no window open; a new fault below still wins
		if (ci.ack && (s_r.st == sfm_pkg::CH_IDLE)) begin
			s_nxt.fault = 1'b0;
		end
		case (s_r.st)
			sfm_pkg::CH_IDLE: begin
				if (chg) begin
					if (ci.tol == '0) begin
						// a zero tolerance cannot time anything
						s_nxt.fault = 1'b1;
						s_nxt.code = sfm_pkg::FV_INIT_CHG;
					end else if (&ci.tol) begin
						// since counter could never exceed tol
						s_nxt.fault = 1'b1;
						s_nxt.code = sfm_pkg::FV_INIT_CHK;
					end else begin
						s_nxt.st = sfm_pkg::CH_WATCH;
						s_nxt.elapsed = (TW+3)'(1);
						s_nxt.since = '0;
					end
				end
			end
			sfm_pkg::CH_WATCH: begin
				s_nxt.elapsed = s_r.elapsed + (TW+3)'(1);
				s_nxt.since = chg ? '0 : s_r.since + TW'(1);
				if (!chg && (s_r.since >= ci.tol)) begin
					// stable longer than one tolerance time: quiet end
					s_nxt.st = sfm_pkg::CH_IDLE;
				end else if (s_r.elapsed >= lim) begin
					s_nxt.st = sfm_pkg::CH_IDLE;
					s_nxt.fault = 1'b1;
					s_nxt.code = sfm_pkg::FV_CHATTER;
				end
			end
			default: begin
				s_nxt.st = sfm_pkg::CH_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ci.busy = (s_r.st == sfm_pkg::CH_WATCH);
	assign ci.fault = s_r.fault;
	assign ci.code = s_r.code;
endmodule : sfm_chatter
`default_nettype wire

// ===== sfm_top.sv
/*
 * sfm_top: safety fault monitor with APB registers, fault latching and interrupt.
 * Assumes: pins come from outside the pclk domain; APB master on pclk; presetn asynchronous, active low.
 */
`default_nettype none
module sfm_top #(
	parameter int TW = sfm_pkg::TOL_W, // tolerance counter width
	parameter logic [TW-1:0] TOL_RESET = TW'(sfm_pkg::TOL_DEFAULT_CYC) // tolerance after reset
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sfm_pkg::AW-1:0] paddr,
	input wire logic [sfm_pkg::DW-1:0] pwdata,
	output logic [sfm_pkg::DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sto_sel_ch1, // torque-off selection, channel 1
	input wire logic sto_sel_ch2, // torque-off selection, channel 2
	input wire logic spp_chk_ch1, // pulse suppression checkback, channel 1
	input wire logic spp_chk_ch2, // pulse suppression checkback, channel 2
	input wire logic torque_off_terminal_a,
	input wire logic torque_off_terminal_b,
	input wire logic term_seen_p1, // terminal state at processor 1
	input wire logic term_seen_p2, // terminal state at processor 2
	input wire logic pulses_cancelled, // power stage reports pulses off
	input wire logic p2_stop_req, // stop request from processor 2
	output logic pulse_inhibit, // high: hold power stage pulses off
	output logic irq
);
	localparam int NPIN = 10; // synchronised pin count

	// refuse widths the counters and the 32-bit register cannot hold
	if (TW < 4 || TW > 28) begin : g_tw_check
		$error("sfm_top: TW must lie in 4..28");
	end

	typedef struct packed {
		logic [sfm_pkg::DW-1:0] prdata; // read data, captured in setup
		logic pready; // access phase answer
		logic pslverr; // unmapped address
		logic en1; // terminal_torque_off_enable_ch1
		logic en2; // terminal_torque_off_enable_ch2
		logic ack; // one-cycle acknowledge
		logic [TW-1:0] tol; // changeover_tolerance_time in cycles
		logic stop_flt; // immediate_stop_fault
		sfm_pkg::sfm_fval_t stop_val; // its fault_value
		logic def_flt; // channel_defect_fault
		sfm_pkg::sfm_fval_t def_val; // its fault_value
		logic [sfm_pkg::IRQ_W-1:0] irq_stat; // sticky events
		logic [sfm_pkg::IRQ_W-1:0] irq_mask; // event enables
		logic irq; // registered interrupt
		logic pulse_inh; // registered inhibit
		logic [TW-1:0] disc_cnt; // discrepancy age in cycles
		logic xchk_req; // cross-check report pending
		sfm_pkg::sfm_fval_t xchk_val; // reported mismatch value
	} sfm_top_st_t;
	sfm_top_st_t s_r, s_nxt;

	logic [NPIN-1:0] pin_q; // synchronised pins
	logic sel1, sel2, chk1, chk2, ta, tb, tp1, tp2, pc, p2s; // pin aliases
	logic setup, acc; // apb phases
	logic [sfm_pkg::IRQ_W-1:0] rd_clr; // bits cleared by a status read
	logic [sfm_pkg::IRQ_W-1:0] ev; // events this cycle
	logic disc; // any channel disagreement
	logic disc_to; // disagreement older than tolerance
	sfm_pkg::sfm_fval_t disc_code; // value for that disagreement
	logic def_new; // defect cause this cycle
	sfm_pkg::sfm_fval_t def_code; // value for that cause
	logic def_raise; // defect latches this cycle
	logic pulse_unexp; // pulses off with no reason
	logic term_noen; // terminal selection not enabled
	logic term_disc; // terminals a and b disagree
	logic stop_cond; // any stop cause present
	sfm_pkg::sfm_fval_t stop_code; // value for that cause

	sfm_chat_if #(.TW(TW)) ci ();

	// every pin passes two flops before use
	sfm_sync #(.W(NPIN)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({sto_sel_ch1, sto_sel_ch2, spp_chk_ch1, spp_chk_ch2, torque_off_terminal_a,
			torque_off_terminal_b, term_seen_p1, term_seen_p2, pulses_cancelled, p2_stop_req}),
		.q(pin_q)
	);
	assign {sel1, sel2, chk1, chk2, ta, tb, tp1, tp2, pc, p2s} = pin_q;

	// chatter checker watches both selections
	sfm_chatter #(.TW(TW)) u_chat (
		.pclk(pclk),
		.presetn(presetn),
		.ci(ci.chk)
	);
	assign ci.sel = {sel1, sel2};
	assign ci.tol = s_r.tol;
	assign ci.ack = s_r.ack;

	// fault causes and their values, highest priority first
	always_comb begin
		// disagreements must outlast one tolerance time to count
		disc = (sel1 != sel2) || (chk1 != chk2) || (tp1 != tp2);
		disc_to = disc && (s_r.disc_cnt >= s_r.tol);
		if (sel1 != sel2) begin
			disc_code = sfm_pkg::FV_SEL_DISC;
		end else if (chk1 != chk2) begin
			disc_code = sfm_pkg::FV_CHK_DISC;
		end else begin
			disc_code = sfm_pkg::FV_SEEN_DISC;
		end
		// channel defect causes
		// a held chatter fault is no live cause on the ack cycle, or one ack could never clear it
		def_new = (ci.fault && !s_r.ack) || disc_to || s_r.xchk_req;
		if (ci.fault) begin
			def_code = ci.code;
		end else if (disc_to) begin
			def_code = disc_code;
		end else begin
			def_code = s_r.xchk_val;
		end
		def_raise = def_new && !s_r.def_flt;
		// immediate stop causes
		pulse_unexp = pc && !sel1 && !sel2 && !s_r.stop_flt;
		term_noen = (ta || tb) && !s_r.en1 && !s_r.en2;
		term_disc = (ta != tb);
		stop_cond = p2s || s_r.def_flt || def_raise || pulse_unexp || term_noen || term_disc;
		if (p2s) begin
			stop_code = sfm_pkg::FV_P2_STOP;
		end else if (s_r.def_flt || def_raise) begin
			stop_code = sfm_pkg::FV_CONSEQ;
		end else if (pulse_unexp || term_noen) begin
			stop_code = sfm_pkg::FV_PULSE;
		end else begin
			stop_code = sfm_pkg::FV_TERM_DISC;
		end
	end

	// bus slave, fault latches and interrupt
	always_comb begin
		s_nxt = s_r;
		setup = psel && !penable;
		acc = psel && penable && s_r.pready;
		rd_clr = '0;
		// one wait-free access cycle: answer prepared during setup
		s_nxt.pready = setup;
		s_nxt.pslverr = setup && !sfm_pkg::sfm_mapped(paddr);
		s_nxt.prdata = '0;
		if (setup && !pwrite) begin
			case (paddr)
				sfm_pkg::OFS_CTRL: begin
					s_nxt.prdata[sfm_pkg::CTRL_EN1] = s_r.en1;
					s_nxt.prdata[sfm_pkg::CTRL_EN2] = s_r.en2;
				end
				sfm_pkg::OFS_TOL: s_nxt.prdata[TW-1:0] = s_r.tol;
				sfm_pkg::OFS_STAT: begin
					s_nxt.prdata[sfm_pkg::ST_STOP] = s_r.stop_flt;
					s_nxt.prdata[sfm_pkg::ST_DEF] = s_r.def_flt;
					s_nxt.prdata[sfm_pkg::ST_BUSY] = ci.busy;
					s_nxt.prdata[sfm_pkg::ST_INH] = s_r.pulse_inh;
				end
				sfm_pkg::OFS_STOP_VAL: s_nxt.prdata[15:0] = s_r.stop_val;
				sfm_pkg::OFS_DEF_VAL: s_nxt.prdata[15:0] = s_r.def_val;
				sfm_pkg::OFS_STOP_ID: s_nxt.prdata = sfm_pkg::sfm_msg_id(sfm_pkg::CLASS_FAULT,
					sfm_pkg::NUM_STOP);
				sfm_pkg::OFS_DEF_ID: s_nxt.prdata = sfm_pkg::sfm_msg_id(sfm_pkg::CLASS_FAULT,
					sfm_pkg::NUM_DEF);
				sfm_pkg::OFS_IRQ_STAT: s_nxt.prdata[sfm_pkg::IRQ_W-1:0] = s_r.irq_stat;
				sfm_pkg::OFS_IRQ_MASK: s_nxt.prdata[sfm_pkg::IRQ_W-1:0] = s_r.irq_mask;
				sfm_pkg::OFS_XCHK: s_nxt.prdata[15:0] = s_r.xchk_val;
				default: s_nxt.prdata = '0;
			endcase
		end
		// writes take effect at the access edge
		s_nxt.ack = 1'b0;
		s_nxt.xchk_req = 1'b0;
		if (acc && pwrite) begin
			case (paddr)
				sfm_pkg::OFS_CTRL: begin
					s_nxt.ack = pwdata[sfm_pkg::CTRL_ACK];
					s_nxt.en1 = pwdata[sfm_pkg::CTRL_EN1];
					s_nxt.en2 = pwdata[sfm_pkg::CTRL_EN2];
				end
				sfm_pkg::OFS_TOL: s_nxt.tol = pwdata[TW-1:0];
				sfm_pkg::OFS_IRQ_MASK: s_nxt.irq_mask = pwdata[sfm_pkg::IRQ_W-1:0];
				sfm_pkg::OFS_XCHK: begin
					// only 1..999 name a cross-check mismatch; others are dropped
					if (pwdata[15:0] >= sfm_pkg::FV_XCHK_MIN && pwdata[15:0] <= sfm_pkg::FV_XCHK_MAX &&
						pwdata[31:16] == 16'h0000) begin
						s_nxt.xchk_req = 1'b1;
						s_nxt.xchk_val = pwdata[15:0];
					end
				end
				default: begin
				end
			endcase
		end
		// status read clears only what it reported
		if (acc && !pwrite && (paddr == sfm_pkg::OFS_IRQ_STAT)) begin
			rd_clr = s_r.prdata[sfm_pkg::IRQ_W-1:0];
		end
		// discrepancy age
		s_nxt.disc_cnt = !disc ? '0 : ((&s_r.disc_cnt) ? s_r.disc_cnt : s_r.disc_cnt + TW'(1));
		// defect latch: first value stays until ack with cause gone
		if (def_raise) begin
			s_nxt.def_flt = 1'b1;
			s_nxt.def_val = def_code;
		end else if (s_r.ack && !def_new && !disc && !ci.busy) begin
			s_nxt.def_flt = 1'b0;
		end
		// stop latch, with the defect as one of its causes
		if (stop_cond && !s_r.stop_flt) begin
			s_nxt.stop_flt = 1'b1;
			s_nxt.stop_val = stop_code;
		end else if (s_r.ack && !p2s && !s_nxt.def_flt && !(pc && !sel1 && !sel2) && !term_noen && !term_disc) begin
			// a defect cleared on this ack releases its consequent stop at the same edge
			s_nxt.stop_flt = 1'b0;
		end
		// events: a new event beats a clearing read
		ev = {def_raise, stop_cond && !s_r.stop_flt};
		s_nxt.irq_stat = (s_r.irq_stat & ~rd_clr) | ev;
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
		s_nxt.pulse_inh = s_nxt.stop_flt;
	end

	// state register; tolerance comes up at its default
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.tol <= TOL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign pulse_inhibit = s_r.pulse_inh;
	assign irq = s_r.irq;
endmodule : sfm_top
`default_nettype wire

// ===== sfm_top_asserts.sv
/* sfm_top_chk: port-level assertions on the safety fault monitor.
   Assumes: one pclk domain, presetn asynchronous and active low, bound below. */
`default_nettype none
module sfm_top_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sfm_pkg::AW-1:0] paddr,
	input wire logic [sfm_pkg::DW-1:0] pwdata,
	input wire logic [sfm_pkg::DW-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sto_sel_ch1,
	input wire logic sto_sel_ch2,
	input wire logic torque_off_terminal_a,
	input wire logic torque_off_terminal_b,
	input wire logic pulses_cancelled,
	input wire logic p2_stop_req,
	input wire logic pulse_inhibit,
	input wire logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic ack_wr; // acknowledge write lands this edge
	logic irq_acc; // any status or mask register access, read or write, lands this edge
	logic unmapped; // address outside the register map
	logic [3:0] ack_h_r; // recent acknowledge writes
	logic [3:0] irq_h_r; // recent interrupt register accesses
	assign ack_wr = psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[0];
	assign irq_acc = psel && penable && pready && (paddr == 8'h1C || paddr == 8'h20);
	assign unmapped = paddr > 8'h24 || paddr[1:0] != 2'h0;
	// short history, since the outputs settle a few edges after the write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_h_r <= 4'h0;
			irq_h_r <= 4'h0;
		end else begin
			ack_h_r <= {ack_h_r[2:0], ack_wr};
			irq_h_r <= {irq_h_r[2:0], irq_acc};
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_unexp;
		pulses_cancelled && !sto_sel_ch1 && !sto_sel_ch2 && !torque_off_terminal_a && !torque_off_terminal_b;
	endsequence
	chk_pready_setup: assert property (s_setup |=> pready) else $error("no pready after setup");
	chk_pready_single: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	chk_slverr_map: assert property (pready |-> pslverr == unmapped) else $error("pslverr wrong for address");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
	chk_stop_req: assert property (p2_stop_req [*3] |-> ##[0:4] pulse_inhibit) else $error("stop request ignored");
	chk_pulse_unexp: assert property (s_unexp [*3] |-> ##[0:4] pulse_inhibit) else $error("pulse loss ignored");
	chk_inh_ack: assert property ($fell(pulse_inhibit) |-> ack_h_r != 4'h0) else $error("stop fault left unasked");
	chk_irq_clear: assert property ($fell(irq) |-> irq_h_r != 4'h0) else $error("irq fell without access");
endmodule : sfm_top_chk
bind sfm_top sfm_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sto_sel_ch1(sto_sel_ch1), .sto_sel_ch2(sto_sel_ch2), .torque_off_terminal_a(torque_off_terminal_a),
	.torque_off_terminal_b(torque_off_terminal_b), .pulses_cancelled(pulses_cancelled),
	.p2_stop_req(p2_stop_req), .pulse_inhibit(pulse_inhibit), .irq(irq));
`default_nettype wire

// ===== sfm_partner.sv
/* sfm_partner: select inputs and second monitoring channel as levels.
   Assumes: the bench sets the commands just after a pclk edge. */
`default_nettype none
module sfm_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic select, // both channels select torque off
	input wire logic [1:0] mode, // 1 selection, 2 checkback, 3 terminal view differ
	input wire logic [3:0] chat, // toggle period in cycles, 0 keeps quiet
	input wire logic stop, // stop request of channel 2
	output logic sto_sel_ch1,
	output logic sto_sel_ch2,
	output logic spp_chk_ch1,
	output logic spp_chk_ch2,
	output logic term_seen_p1,
	output logic term_seen_p2,
	output logic p2_stop_req
);
	typedef struct packed {logic [3:0] cnt; logic tog;} sfm_pt_st_t;
	sfm_pt_st_t st_r; // chatter counter and toggle
	sfm_pt_st_t st_nxt;
	// contact bounce: both channels flip together, so only timing is wrong
	always_comb begin
		st_nxt = st_r;
		if (chat == 4'h0) begin
			st_nxt = '0;
		end else if (st_r.cnt + 4'h1 >= chat) begin
			st_nxt.cnt = 4'h0;
			st_nxt.tog = !st_r.tog;
		end else begin
			st_nxt.cnt = st_r.cnt + 4'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign sto_sel_ch1 = select ^ st_r.tog;
	assign sto_sel_ch2 = select ^ st_r.tog ^ (mode == 2'h1);
	assign spp_chk_ch1 = select;
	assign spp_chk_ch2 = select ^ (mode == 2'h2);
	assign term_seen_p1 = select;
	assign term_seen_p2 = select ^ (mode == 2'h3);
	assign p2_stop_req = stop;
endmodule : sfm_partner
`default_nettype wire

// ===== sfm_tb.sv
/* tb_top: self-checking bench of the fault monitor over APB.
   Assumes: tolerance reset shortened to 8 cycles; partner drives the channel pins. */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pulse_inhibit, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic s1, s2, c1, c2, v1, v2, p2s, sel, stop, canc, term_a, term_b, err_q;
	logic [1:0] mode;
	logic [3:0] chat;
	int fail_count, check_count;
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	sfm_top #(.TOL_RESET(24'h000008)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sto_sel_ch1(s1), .sto_sel_ch2(s2), .spp_chk_ch1(c1), .spp_chk_ch2(c2), .torque_off_terminal_a(term_a),
		.torque_off_terminal_b(term_b), .term_seen_p1(v1), .term_seen_p2(v2), .pulses_cancelled(canc),
		.p2_stop_req(p2s), .pulse_inhibit(pulse_inhibit), .irq(irq));
	sfm_partner u_partner (.pclk(pclk), .presetn(presetn), .select(sel), .mode(mode), .chat(chat), .stop(stop),
		.sto_sel_ch1(s1), .sto_sel_ch2(s2), .spp_chk_ch1(c1), .spp_chk_ch2(c2), .term_seen_p1(v1),
		.term_seen_p2(v2), .p2_stop_req(p2s));
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : final_report
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmp
	// one transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			$display("Error at %0t: no pready", $time);
			final_report();
		end
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		cmp(rd_q, exp, what);
	endtask : rd
	// bounded wait on the inhibit output, then judged
	task automatic wait_inh(input logic v);
		int n;
		n = 0;
		while (pulse_inhibit !== v && n < 100) begin
			@(posedge pclk);
			n++;
		end
		cmp({31'h0, pulse_inhibit}, {31'h0, v}, "pulse_inhibit");
		if (n >= 100) final_report();
	endtask : wait_inh
	// removes every cause, acknowledges and expects a clean state
	task automatic clear_all(input logic [31:0] en);
		{sel, stop, canc, term_a, term_b} <= 5'h0;
		mode <= 2'h0;
		chat <= 4'h0;
		repeat (30) @(posedge pclk);
		apb(1'b1, 8'h00, en | 32'h1);
		apb(1'b0, 8'h1C, 32'h0);
		wait_inh(1'b0);
		rd(8'h08, 32'h0, "status after ack");
	endtask : clear_all
	task automatic t_regs();
		rd(8'h14, 32'h46000640, "stop id");
		rd(8'h18, 32'h4600064B, "defect id");
		rd(8'h04, 32'h8, "tolerance reset");
		rd(8'h20, 32'h0, "mask reset");
		rd(8'h28, 32'h0, "unmapped data");
		cmp({31'h0, err_q}, 32'h1, "unmapped error");
		apb(1'b1, 8'h08, 32'hF);
		rd(8'h08, 32'h0, "status read only");
		$display("regs test done");
	endtask : t_regs
	task automatic t_stop();
		apb(1'b1, 8'h20, 32'h3);
		stop <= 1'b1;
		wait_inh(1'b1);
		rd(8'h0C, 32'h0, "stop value");
		rd(8'h08, 32'h9, "status stop");
		cmp({31'h0, irq}, 32'h1, "irq raised");
		rd(8'h1C, 32'h1, "irq status");
		rd(8'h1C, 32'h0, "irq status cleared");
		repeat (2) @(posedge pclk);
		cmp({31'h0, irq}, 32'h0, "irq dropped");
		apb(1'b1, 8'h00, 32'h1);
		repeat (4) @(posedge pclk);
		cmp({31'h0, pulse_inhibit}, 32'h1, "ack lost with cause");
		clear_all(32'h0);
		$display("stop test done");
	endtask : t_stop
	task automatic t_pulse();
		apb(1'b1, 8'h20, 32'h0);
		canc <= 1'b1;
		wait_inh(1'b1);
		rd(8'h0C, 32'h3ED, "pulse loss value");
		cmp({31'h0, irq}, 32'h0, "irq masked");
		apb(1'b1, 8'h20, 32'h3);
		repeat (3) @(posedge pclk);
		cmp({31'h0, irq}, 32'h1, "irq unmasked");
		clear_all(32'h0);
		{term_a, term_b} <= 2'h3;
		wait_inh(1'b1);
		rd(8'h0C, 32'h3ED, "terminals without enable");
		clear_all(32'h6);
		term_a <= 1'b1;
		wait_inh(1'b1);
		rd(8'h0C, 32'h406, "terminal mismatch");
		clear_all(32'h0);
		$display("pulse test done");
	endtask : t_pulse
	task automatic t_disc();
		logic [31:0] exp [3] = '{32'h7D0, 32'h7D1, 32'h7D3};
		for (int m = 1; m <= 3; m++) begin
			mode <= 2'(m);
			wait_inh(1'b1);
			rd(8'h10, exp[m-1], "defect value");
			rd(8'h0C, 32'h270F, "consequent stop");
			clear_all(32'h0);
		end
		apb(1'b1, 8'h24, 32'h3E8);
		repeat (4) @(posedge pclk);
		rd(8'h08, 32'h0, "cross-check 1000 ignored");
		apb(1'b1, 8'h24, 32'h3E7);
		wait_inh(1'b1);
		rd(8'h10, 32'h3E7, "cross-check value");
		clear_all(32'h0);
		$display("discrepancy test done");
	endtask : t_disc
	task automatic t_chat();
		logic [31:0] tol [2] = '{32'hFFFFFF, 32'h0};
		logic [31:0] exp [2] = '{32'h3EA, 32'h3E9};
		chat <= 4'h3;
		wait_inh(1'b1);
		rd(8'h10, 32'h3E8, "chatter value");
		rd(8'h0C, 32'h270F, "chatter stop");
		clear_all(32'h0);
		sel <= 1'b1;
		repeat (3) @(posedge pclk);
		rd(8'h08, 32'h4, "window open");
		repeat (20) @(posedge pclk);
		rd(8'h08, 32'h0, "window closed quietly");
		clear_all(32'h0);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, 8'h04, tol[i]);
			sel <= 1'b1;
			wait_inh(1'b1);
			rd(8'h10, exp[i], "timer init value");
			apb(1'b1, 8'h04, 32'h8);
			clear_all(32'h0);
		end
		$display("chatter test done");
	endtask : t_chat
	initial begin
		{presetn, psel, penable, pwrite, sel, stop, canc, term_a, term_b} = 9'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mode = 2'h0;
		chat = 4'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_stop();
		t_pulse();
		t_disc();
		t_chat();
		final_report();
	end
	// cuts a hang short
	initial begin
		#400000;
		fail_count++;
		$display("Error at %0t: run timeout", $time);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
